// file: src/vid_out_pkg.sv
package vid_out_pkg;

  // Output standard selected by software.
  localparam logic [2:0] MODE_SD = 3'h0;
  localparam logic [2:0] MODE_HD = 3'h1;
  localparam logic [2:0] MODE_DL = 3'h2;
  localparam logic [2:0] MODE_3GA = 3'h3;
  localparam logic [2:0] MODE_3GB = 3'h4;

  // Register byte addresses.
  localparam logic [31:0] CTRL_OFF = 32'h0000_0000;
  localparam logic [31:0] STAT_OFF = 32'h0000_0004;

  // Control register fields.
  localparam int MODE_LSB = 0;
  localparam int PROG_BIT = 3;

  // Status register fields.
  localparam int ST_CRC_LSB = 0;
  localparam int ST_AP_LSB = 2;
  localparam int ST_FLD_LSB = 4;
  localparam int ST_VLD_LSB = 6;

  // Reset values.
  localparam logic [2:0] MODE_RST = 3'h0;
  localparam logic PROG_RST = 1'b0;

  // Width of one video word.
  localparam int WORD_W = 10;

  // AHB transfer type bit that marks NONSEQ or SEQ.
  localparam int TRANS_ACT_BIT = 1;

endpackage

// file: src/crc_link_if.sv
`timescale 1ns/10ps
`default_nettype none

// Per-link chroma check events and the held error flags.
interface crc_link_if;
  logic [1:0] fail; // Check failed, one-cycle pulse per link.
  logic [1:0] hblank; // Horizontal blanking level per link.
  logic [1:0] line_go; // Start of the next line, pulse per link.
  logic [1:0] flag; // Held error flag per link.
  modport drv (output fail, output hblank, output line_go, input flag);
  modport hold (input fail, input hblank, input line_go, output flag);
endinterface // crc_link_if

`default_nettype wire

// file: src/crc_flag_hold.sv
`timescale 1ns/10ps
`default_nettype none

module crc_flag_hold (
  input wire logic clk, // Recovered parallel clock.
  input wire logic reset, // Asynchronous reset, active high.
  crc_link_if.hold lnk // Events in, held flags out.
);

  // All state of the holder.
  typedef struct packed {
    logic [1:0] flag; // Held error per link.
  } hold_t;

  hold_t s_r;
  hold_t s_nxt;

  // A failure taken in blanking sets the flag; the next line clears it.
  // Set is checked last so a coincident failure is never lost.
  always_comb begin
    s_nxt = s_r;
    for (int i = 0; i < 2; i++) begin
      if (lnk.line_go[i]) begin
        s_nxt.flag[i] = 1'b0;
      end
      if (lnk.fail[i] && lnk.hblank[i]) begin
        s_nxt.flag[i] = 1'b1;
      end
    end
  end

  // State register.
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign lnk.flag = s_r.flag;

  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  // A failure seen in blanking shows on the next edge.
  crc_set_a: assert property ((lnk.fail[0] && lnk.hblank[0]) |=> lnk.flag[0])
    else $error("Link A chroma flag did not set.");

  // The flag stays until a new line begins.
  crc_keep_a: assert property ((lnk.flag[1] && !lnk.line_go[1]) |=> lnk.flag[1])
    else $error("Link B chroma flag dropped early.");

  // The flag only rises from a failure taken in blanking.
  crc_cause_a: assert property ($rose(lnk.flag[0]) |-> $past(lnk.fail[0] && lnk.hblank[0]))
    else $error("Link A chroma flag rose without cause.");

endmodule // crc_flag_hold

`default_nettype wire

// file: src/vid_out_port.sv
// Our own choices: register access over AHB-Lite and the placing of the registers.
`timescale 1ns/10ps
`default_nettype none

// Function
// - HD: chroma error on bit 0 only.
// - Dual link: error bit 1 B, bit 0 A.
// - 3G A: chroma error on bit 0 only.
// - 3G B: error bit 1 A, bit 0 B.
// - Active flag high during active picture.
// - Active flag bit 0; 3G B splits links.
// - SD: multiplex on 9:0, 19:10 unused.
// - HD, 3G A: luma 19:10, chroma 9:0.
// - Dual link: B luma, B chroma, A luma, A chroma.
// - 3G B: link A 19:10, link B 9:0.
// - Valid bit 0 marks a valid word.
// - 3G B: valid bit 1 A, bit 0 B.
// - Interlaced field flag: 0 first, 1 second.
// - Progressive field flag always 0.
// - Field flag bit 0; unused in 3G.
// - Error flag held until next line.
// - Error set in blanking, refers to previous line.
module vid_out_port
  import vid_out_pkg::*;
#(
  parameter int word_w = WORD_W // Width of one video word.
) (
  input wire logic clk, // Recovered parallel clock.
  input wire logic reset, // Asynchronous reset, active high.
  input wire logic hsel, // AHB slave select.
  input wire logic [31:0] haddr, // AHB address.
  input wire logic [1:0] htrans, // AHB transfer type.
  input wire logic hwrite, // AHB write, high for write.
  input wire logic [2:0] hsize, // AHB size, word only.
  input wire logic [31:0] hwdata, // AHB write data.
  input wire logic hready, // AHB bus ready.
  output logic hreadyout, // Slave ready.
  output logic hresp, // Slave response, always OKAY.
  output logic [31:0] hrdata, // AHB read data.
  input wire logic a_valid, // Link A word valid.
  input wire logic b_valid, // Link B word valid.
  input wire logic [word_w-1:0] a_y, // Link A luma or multiplex word.
  input wire logic [word_w-1:0] a_c, // Link A chroma word.
  input wire logic [word_w-1:0] b_y, // Link B luma or multiplex word.
  input wire logic [word_w-1:0] b_c, // Link B chroma word.
  input wire logic [1:0] ap_in, // Active picture per link, bit 1 B.
  input wire logic [1:0] field_in, // Field bit per link, bit 1 B.
  input wire logic [1:0] hblank_in, // Horizontal blanking per link.
  input wire logic [1:0] line_go_in, // Next line begins, pulse per link.
  input wire logic [1:0] crc_fail_in, // Chroma check failed, pulse.
  output logic [4*word_w-1:0] rxdata_out, // Parallel video words.
  output logic [1:0] data_valid_out, // Valid and link marks.
  output logic [1:0] crc_error_c, // Chroma error flags.
  output logic [1:0] active_picture_flag, // Active picture flags.
  output logic [1:0] field_flag // Field flags.
);

  localparam int DW = 4 * word_w;

  // All state of the port.
  typedef struct packed {
    logic [2:0] mode; // Selected standard.
    logic prog; // Progressive source.
    logic wr_pend; // Write data phase pending.
    logic [31:0] wr_addr; // Address of the pending write.
    logic [31:0] rdata; // Read data for the data phase.
    logic [DW-1:0] data; // Output words.
    logic [1:0] valid; // Output valid marks.
    logic [1:0] ap; // Output active picture flags.
    logic [1:0] field; // Output field flags.
    logic ok; // High from the first edge after reset.
  } port_t;

  port_t s_r;
  port_t s_nxt;

  crc_link_if crc_if ();

  // Chroma error holding for both links.
  crc_flag_hold u_hold (
    .clk(clk),
    .reset(reset),
    .lnk(crc_if.hold)
  );

  // Events go to the holder untouched, in the same cycle as the data.
  assign crc_if.fail = crc_fail_in;
  assign crc_if.hblank = hblank_in;
  assign crc_if.line_go = line_go_in;

  // Steers a per-link pair onto the two output bits.
  // In 3G Level B the bus carries link A on bit 1; in dual link with use_b bit 1 is link B, else bit 1 is 0.
  function automatic logic [1:0] pair_map(
    input logic [2:0] mode,
    input logic [1:0] ab, // Bit 1 link B, bit 0 link A.
    input logic use_b // Use link B in dual link.
  );
    logic [1:0] r;
    r = 2'h0;
    if (mode == MODE_3GB) begin
      r = {ab[0], ab[1]};
    end else if (mode == MODE_DL && use_b) begin
      r = ab;
    end else begin
      r = {1'b0, ab[0]};
    end
    return r;
  endfunction

  // Builds the word that a read returns.
  function automatic logic [31:0] read_word(
    input logic [31:0] addr,
    input port_t st,
    input logic [1:0] crc
  );
    logic [31:0] w;
    w = 32'h0;
    if (addr == CTRL_OFF) begin
      w[MODE_LSB +: 3] = st.mode;
      w[PROG_BIT] = st.prog;
    end else if (addr == STAT_OFF) begin
      w[ST_CRC_LSB +: 2] = crc;
      w[ST_AP_LSB +: 2] = st.ap;
      w[ST_FLD_LSB +: 2] = st.field;
      w[ST_VLD_LSB +: 2] = st.valid;
    end else begin
      w = 32'h0; // Unmapped addresses read as zero.
    end
    return w;
  endfunction

  // Next state: bus slave first, then the video mapping.
  always_comb begin
    s_nxt = s_r;
    s_nxt.ok = 1'b1;
    s_nxt.wr_pend = 1'b0;

    // Write data phase: only the control word is writable.
    if (s_r.wr_pend && s_r.wr_addr == CTRL_OFF) begin
      s_nxt.mode = hwdata[MODE_LSB +: 3];
      s_nxt.prog = hwdata[PROG_BIT];
    end

    // Address phase. Reads use the next state so that a read
    // right after a write sees the new value.
    if (hsel && htrans[TRANS_ACT_BIT] && hready) begin
      if (hwrite) begin
        s_nxt.wr_pend = 1'b1;
        s_nxt.wr_addr = haddr;
      end else begin
        s_nxt.rdata = read_word(haddr, s_nxt, crc_error_c);
      end
    end

    // Data words, one register stage for every output.
    s_nxt.data = '0;
    case (s_r.mode)
      MODE_HD, MODE_3GA: begin
        s_nxt.data[2*word_w-1:0] = {a_y, a_c};
      end
      MODE_DL: begin
        s_nxt.data = {b_y, b_c, a_y, a_c};
      end
      MODE_3GB: begin
        s_nxt.data[2*word_w-1:0] = {a_y, b_y};
      end
      default: begin
        s_nxt.data[word_w-1:0] = a_y;
      end
    endcase

    // Valid marks: bit 0 follows link A's valid, link marks in 3G B.
    if (s_r.mode == MODE_3GB) begin
      s_nxt.valid = {a_valid, b_valid};
    end else begin
      s_nxt.valid = {1'b0, a_valid};
    end

    // Active picture, split by link only in 3G Level B.
    s_nxt.ap = pair_map(s_r.mode, ap_in, 1'b0);

    // Field flag: unused in 3G, pinned low for progressive.
    if (s_r.mode == MODE_3GA || s_r.mode == MODE_3GB) begin
      s_nxt.field = 2'h0;
    end else if (s_r.prog) begin
      s_nxt.field = 2'h0;
    end else begin
      s_nxt.field = {1'b0, field_in[0]};
    end
  end

  // State register. Everything moves on the same edge so flags
  // stay aligned with the word they describe.
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      s_r <= '0;
      s_r.mode <= MODE_RST;
      s_r.prog <= PROG_RST;
    end else begin
      s_r <= s_nxt;
    end
  end

  // The slave never stalls, so a read answers in its data phase.
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = s_r.rdata;

  // Outputs come straight from the state flops.
  assign rxdata_out = s_r.data;
  assign data_valid_out = s_r.valid;
  assign active_picture_flag = s_r.ap;
  assign field_flag = s_r.field;

  // Chroma flags are held flops steered by the mode flop. SD has no
  // line check, so both bits stay low there.
  always_comb begin
    case (s_r.mode)
      MODE_HD, MODE_3GA: begin
        crc_error_c = {1'b0, crc_if.flag[0]};
      end
      MODE_DL, MODE_3GB: begin
        crc_error_c = pair_map(s_r.mode, crc_if.flag, 1'b1);
      end
      default: begin
        crc_error_c = 2'h0;
      end
    endcase
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  // The standard selected in the current cycle.
  sequence mode_is(logic [2:0] m);
    s_r.mode == m;
  endsequence

  // SD words land on the low ten bits only.
  sd_data_a: assert property ((s_r.ok and mode_is(MODE_SD)) |=>
      rxdata_out[DW-1:word_w] == '0 && rxdata_out[word_w-1:0] == $past(a_y))
    else $error("SD word misplaced.");

  // HD luma above chroma in one word.
  hd_data_a: assert property ((s_r.ok and mode_is(MODE_HD)) |=>
      rxdata_out[2*word_w-1:0] == $past({a_y, a_c}))
    else $error("HD luma and chroma misplaced.");

  // Dual link word order.
  dl_data_a: assert property ((s_r.ok and mode_is(MODE_DL)) |=>
      rxdata_out == $past({b_y, b_c, a_y, a_c}))
    else $error("Dual link words misplaced.");

  // Level B multiplex streams.
  lvb_data_a: assert property ((s_r.ok and mode_is(MODE_3GB)) |=>
      rxdata_out[2*word_w-1:word_w] == $past(a_y) && rxdata_out[word_w-1:0] == $past(b_y))
    else $error("Level B streams misplaced.");

  // Valid bit 0 follows link A one cycle later outside Level B.
  vld_bit_a: assert property ((s_r.ok && s_r.mode != MODE_3GB) |=>
      data_valid_out == {1'b0, $past(a_valid)})
    else $error("Valid mark wrong.");

  // Level B valid marks per virtual link.
  vld_link_a: assert property ((s_r.ok and mode_is(MODE_3GB)) |=>
      data_valid_out == $past({a_valid, b_valid}))
    else $error("Level B valid marks wrong.");

  // Active picture tracks its source with one cycle of delay.
  ap_track_a: assert property ((s_r.ok and mode_is(MODE_HD)) |=>
      active_picture_flag == {1'b0, $past(ap_in[0])})
    else $error("Active picture flag wrong.");

  // Level B active picture swaps links onto the bus.
  ap_split_a: assert property ((s_r.ok and mode_is(MODE_3GB)) |=>
      active_picture_flag == {$past(ap_in[0]), $past(ap_in[1])})
    else $error("Level B active picture wrong.");

  // Interlaced field bit copied in dual link.
  fld_copy_a: assert property (((s_r.ok && !s_r.prog) and mode_is(MODE_DL)) |=>
      field_flag == {1'b0, $past(field_in[0])})
    else $error("Field flag wrong.");

  // Progressive video keeps the field flag low.
  fld_prog_a: assert property (s_r.ok && s_r.prog |=> field_flag == 2'h0)
    else $error("Progressive field flag not low.");

  // Field flag unused in both 3G modes.
  fld_3g_a: assert property ((mode_is(MODE_3GA) or mode_is(MODE_3GB)) |=>
      field_flag == 2'h0)
    else $error("3G field flag not low.");

  // Single link modes never raise chroma error bit 1.
  crc_one_a: assert property ((mode_is(MODE_HD) or mode_is(MODE_3GA)) |->
      crc_error_c[1] == 1'b0 && crc_error_c[0] == crc_if.flag[0])
    else $error("Single link chroma flag wrong.");

  // Dual link keeps link order; Level B swaps it.
  crc_pair_a: assert property (mode_is(MODE_DL) |-> crc_error_c == crc_if.flag)
    else $error("Dual link chroma flags wrong.");

  crc_swap_a: assert property (mode_is(MODE_3GB) |->
      crc_error_c == {crc_if.flag[0], crc_if.flag[1]})
    else $error("Level B chroma flags wrong.");

  // A control write reaches the mode one edge after its data phase.
  ctrl_wr_a: assert property (s_r.wr_pend && s_r.wr_addr == CTRL_OFF |=>
      s_r.mode == $past(hwdata[MODE_LSB +: 3]))
    else $error("Control write lost.");

  // Level A keeps the HD order and leaves the upper words low.
  lva_data_a: assert property ((s_r.ok and mode_is(MODE_3GA)) |=>
      rxdata_out[DW-1:2*word_w] == '0 && rxdata_out[2*word_w-1:0] == $past({a_y, a_c}))
    else $error("Level A luma and chroma misplaced.");

  // Level B uses only the low two words; the upper ones must stay quiet.
  lvb_high_a: assert property ((s_r.ok and mode_is(MODE_3GB)) |=>
      rxdata_out[DW-1:2*word_w] == '0)
    else $error("Level B upper words not low.");

  // Dual link shows only link A's active picture, on bit 0.
  ap_dl_a: assert property ((s_r.ok and mode_is(MODE_DL)) |=>
      active_picture_flag == {1'b0, $past(ap_in[0])})
    else $error("Dual link active picture wrong.");

  // Level A uses bit 0 of the active picture flag alone.
  ap_lva_a: assert property ((s_r.ok and mode_is(MODE_3GA)) |=>
      active_picture_flag == {1'b0, $past(ap_in[0])})
    else $error("Level A active picture wrong.");

  // Interlaced SD and HD copy link A's field bit onto bit 0.
  fld_sdhd_a: assert property (((s_r.ok && !s_r.prog) and (mode_is(MODE_SD) or mode_is(MODE_HD))) |=>
      field_flag == {1'b0, $past(field_in[0])})
    else $error("SD or HD field flag wrong.");

  // A status read reports the flags that stood when its address phase was taken.
  st_read_a: assert property ((hsel && htrans[TRANS_ACT_BIT] && hready && !hwrite && haddr == STAT_OFF) |=>
      hrdata[7:0] == $past({data_valid_out, field_flag, active_picture_flag, crc_error_c}))
    else $error("Status read disagrees with outputs.");

  // Address phase of a control write, then its data phase one cycle later.
  sequence ctrl_write_s;
    (hsel && htrans[TRANS_ACT_BIT] && hready && hwrite && haddr == CTRL_OFF) ##1 1'b1;
  endsequence

  // The mode follows the data of a control write on the edge after its data phase.
  ctrl_seq_a: assert property (ctrl_write_s |=> s_r.mode == $past(hwdata[MODE_LSB +: 3]))
    else $error("Control write sequence lost.");

endmodule // vid_out_port

`default_nettype wire

// file: tb/vid_sink.sv
`timescale 1ns/10ps
`default_nettype none

// Downstream video logic that keeps only words marked valid.
module vid_sink (
  input wire logic clk, // Recovered parallel clock.
  input wire logic reset, // Asynchronous reset, active high.
  input wire logic [39:0] rxdata_out, // Parallel words from the port.
  input wire logic [1:0] data_valid_out, // Valid marks from the port.
  output logic [39:0] last_word // Last word taken while valid.
);
  // Words between valid marks are ignored, so stale data never leaks through.
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      last_word <= 40'h0;
    end else if (data_valid_out != 2'h0) begin
      last_word <= rxdata_out;
    end
  end
endmodule // vid_sink

`default_nettype wire

// file: tb/test_vid_out_port.sv
`timescale 1ns/10ps
`default_nettype none

// Self-checking bench for the receiver's parallel output port.
module test_vid_out_port
  import vid_out_pkg::*;
;
  logic clk, reset, hsel, hwrite, hreadyout, hresp, a_valid, b_valid;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [1:0] htrans, ap_in, field_in, hblank_in, line_go_in, crc_fail_in;
  logic [1:0] data_valid_out, crc_error_c, active_picture_flag, field_flag;
  logic [2:0] hsize;
  logic [9:0] a_y, a_c, b_y, b_c;
  logic [39:0] rxdata_out, last_word;
  int error_cnt, num_checks;

  // The single slave's ready feeds the bus ready back.
  vid_out_port dut (.clk(clk), .reset(reset), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
    .a_valid(a_valid), .b_valid(b_valid), .a_y(a_y), .a_c(a_c), .b_y(b_y), .b_c(b_c), .ap_in(ap_in),
    .field_in(field_in), .hblank_in(hblank_in), .line_go_in(line_go_in), .crc_fail_in(crc_fail_in),
    .rxdata_out(rxdata_out), .data_valid_out(data_valid_out), .crc_error_c(crc_error_c),
    .active_picture_flag(active_picture_flag), .field_flag(field_flag));

  vid_sink sink (.clk(clk), .reset(reset), .rxdata_out(rxdata_out), .data_valid_out(data_valid_out),
    .last_word(last_word));

  // Prints the verdict and ends the run.
  task automatic stop_test();
    if (error_cnt == 0 && num_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  // Compares one value and counts the result.
  task automatic chk(input string name, input logic [39:0] e, input logic [39:0] g);
    num_checks++;
    if (g !== e) begin
      $display("BAD %s expected %h seen %h", name, e, g);
      error_cnt++;
    end
  endtask

  // Waits for the next edge with ready high; only the watchdog ends a stuck wait.
  task automatic wait_rdy();
    @(posedge clk);
    while (hreadyout !== 1'b1) begin
      @(posedge clk);
    end
  endtask

  // One single AHB-Lite word transfer; read data is taken at the data phase's closing edge.
  task automatic ahb(input logic wr, input logic [31:0] a, input logic [31:0] wd, output logic [31:0] q);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= wr;
    wait_rdy();
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    wait_rdy();
    q = hrdata;
    chk("hresp", 40'h0, {39'h0, hresp});
  endtask

  // Reset values, an unmapped address and the read-only status word.
  task automatic reset_regs();
    chk("outputs", 40'h0, {32'h0, crc_error_c, active_picture_flag, field_flag, data_valid_out});
    ahb(1'b0, CTRL_OFF, 32'h0, rd);
    chk("ctrl", 40'h0, {8'h0, rd});
    ahb(1'b0, 32'h0000_0100, 32'h0, rd);
    chk("unmapped", 40'h0, {8'h0, rd});
    ahb(1'b1, STAT_OFF, 32'hffff_ffff, rd);
    ahb(1'b0, STAT_OFF, 32'h0, rd);
    chk("status", 40'h0, {8'h0, rd});
  endtask

  // Every mode with two value sets: data map, valid, active and field flags.
  task automatic modes();
    logic [39:0] ed, es;
    logic [1:0] ev, ea, ef;
    logic prog;
    es = 40'h0;
    for (int m = 0; m < 5; m++) begin
      for (int p = 0; p < 2; p++) begin
        prog = (p == 1) && (m == 2);
        ahb(1'b1, CTRL_OFF, {28'h0, prog, m[2:0]}, rd);
        ahb(1'b0, CTRL_OFF, 32'h0, rd);
        chk("ctrl", {36'h0, prog, m[2:0]}, {8'h0, rd});
        a_y <= 10'h3a5 ^ {10{p[0]}};
        a_c <= 10'h0f1 ^ {10{p[0]}};
        b_y <= 10'h2c3 ^ {10{p[0]}};
        b_c <= 10'h155 ^ {10{p[0]}};
        a_valid <= ~p[0];
        b_valid <= p[0];
        ap_in <= p[0] ? 2'h1 : 2'h2;
        field_in <= p[0] ? 2'h1 : 2'h2;
        @(posedge clk);
        #1;
        case (m[2:0])
          MODE_HD, MODE_3GA: ed = {20'h0, a_y, a_c};
          MODE_DL: ed = {b_y, b_c, a_y, a_c};
          MODE_3GB: ed = {20'h0, a_y, b_y};
          default: ed = {30'h0, a_y};
        endcase
        ev = (m == 4) ? {a_valid, b_valid} : {1'b0, a_valid};
        ea = (m == 4) ? {ap_in[0], ap_in[1]} : {1'b0, ap_in[0]};
        ef = (m >= 3 || prog) ? 2'h0 : {1'b0, field_in[0]};
        chk("rxdata", ed, rxdata_out);
        chk("valid", {38'h0, ev}, {38'h0, data_valid_out});
        chk("active", {38'h0, ea}, {38'h0, active_picture_flag});
        chk("field", {38'h0, ef}, {38'h0, field_flag});
        // The sink keeps the last word taken while some valid bit was high.
        if (ev != 2'h0) begin
          es = ed;
        end
        @(posedge clk);
        #1;
        chk("sink", es, last_word);
        ahb(1'b0, STAT_OFF, 32'h0, rd);
        chk("status", {32'h0, ev, ef, ea, 2'h0}, {32'h0, rd[7:2], 2'h0});
      end
    end
  endtask

  // Sends one event pulse and checks the steered error flags two edges later.
  task automatic pulse(input logic [2:0] m, input logic [1:0] f, input logic [1:0] g, input logic [1:0] h,
      input logic [1:0] fl);
    logic [1:0] e;
    crc_fail_in <= f;
    line_go_in <= g;
    hblank_in <= h;
    @(posedge clk);
    crc_fail_in <= 2'h0;
    line_go_in <= 2'h0;
    @(posedge clk);
    #1;
    case (m)
      MODE_HD, MODE_3GA: e = {1'b0, fl[0]};
      MODE_DL: e = fl;
      MODE_3GB: e = {fl[0], fl[1]};
      default: e = 2'h0;
    endcase
    chk("crc_error_c", {38'h0, e}, {38'h0, crc_error_c});
    ahb(1'b0, STAT_OFF, 32'h0, rd);
    chk("status_crc", {38'h0, e}, {38'h0, rd[ST_CRC_LSB +: 2]});
  endtask

  // Set in blanking, refusal outside it, hold, and clearing per link.
  task automatic crc_flags();
    for (int m = 0; m < 5; m++) begin
      ahb(1'b1, CTRL_OFF, {29'h0, m[2:0]}, rd);
      pulse(m[2:0], 2'h1, 2'h0, 2'h3, 2'h1);
      pulse(m[2:0], 2'h2, 2'h0, 2'h1, 2'h1);
      pulse(m[2:0], 2'h2, 2'h0, 2'h3, 2'h3);
      pulse(m[2:0], 2'h0, 2'h1, 2'h3, 2'h2);
      pulse(m[2:0], 2'h0, 2'h2, 2'h3, 2'h0);
      // A failure and a new line in the same cycle: the set wins.
      pulse(m[2:0], 2'h1, 2'h1, 2'h3, 2'h1);
      pulse(m[2:0], 2'h0, 2'h1, 2'h3, 2'h0);
    end
  endtask

  // Clock at 25 MHz.
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  // A hang would stall the verdict, so a fixed span cuts it short.
  initial begin
    #(40 * 5000);
    error_cnt++;
    stop_test();
  end

  // Main sequence: idle inputs, reset for ten cycles, then the scenarios.
  initial begin
    {hsel, hwrite, a_valid, b_valid, haddr, hwdata, htrans} = '0;
    {ap_in, field_in, hblank_in, line_go_in, crc_fail_in, a_y, a_c, b_y, b_c} = '0;
    hsize = 3'h2;
    error_cnt = 0;
    num_checks = 0;
    reset = 1'b1;
    repeat (10) @(posedge clk);
    reset <= 1'b0;
    @(posedge clk);
    #1;
    reset_regs();
    modes();
    crc_flags();
    stop_test();
  end
endmodule // test_vid_out_port

`default_nettype wire
